//--- pkg/dsda_pkg.sv
package dsda_pkg;

    localparam int EA_W         = 16;
    localparam int DATA_W       = 16;
    localparam int WREG_N       = 16;
    localparam int WSEL_W       = 4;
    localparam int LIT_W        = 16;
    localparam int DMA_WORDS    = 512;
    localparam int DMA_IDX_W    = 9;
    localparam logic [EA_W-1:0] XY_BOUNDARY  = 16'h0800;
    localparam logic [EA_W-1:0] DMA_BASE     = 16'hfc00;
    localparam logic [3:0]      PF_X_LO      = 4'h8;
    localparam logic [3:0]      PF_X_HI      = 4'h9;
    localparam logic [3:0]      PF_Y_LO      = 4'ha;
    localparam logic [3:0]      PF_Y_HI      = 4'hb;
    localparam logic [EA_W-1:0] MOD_STEP_LIM = 16'h0002;

    typedef enum logic [2:0] {
        DSDA_FILE_DIRECT,
        DSDA_REG_INDIRECT,
        DSDA_POST_MOD,
        DSDA_PRE_MOD,
        DSDA_REG_INDEXED,
        DSDA_LIT_OFFSET
    } dsda_mode_e;

    typedef struct packed {
        logic                    valid;
        logic                    write;
        dsda_mode_e              mode;
        logic [WSEL_W-1:0]       base_sel;
        logic [LIT_W-1:0]        literal;
        logic                    bitrev;
    } dsda_req_s;

    typedef struct packed {
        logic                    en;
        logic [EA_W-1:0]         start;
        logic [EA_W-1:0]         stop;
    } dsda_modulo_s;

endpackage : dsda_pkg

//--- hw/dsda_dpram.sv
module dsda_dpram
    import dsda_pkg::*;
(
    // clock, no reset
    input  wire logic                 ref_clk_in,
    // cpu port
    input  wire logic                 a_en_in,
    input  wire logic                 a_we_in,
    input  wire logic [DMA_IDX_W-1:0] a_addr_in,
    input  wire logic [DATA_W-1:0]    a_wdata_in,
    output logic      [DATA_W-1:0]    a_rdata_out,
    // dma port
    input  wire logic                 b_en_in,
    input  wire logic                 b_we_in,
    input  wire logic [DMA_IDX_W-1:0] b_addr_in,
    input  wire logic [DATA_W-1:0]    b_wdata_in,
    output logic      [DATA_W-1:0]    b_rdata_out
);

    logic [DATA_W-1:0] mem [DMA_WORDS];
    logic              b_blocked;

    // cpu wins a same-location write; the dma write is simply dropped
    assign b_blocked = a_en_in && a_we_in && (a_addr_in == b_addr_in);

    always_ff @(posedge ref_clk_in) begin
        if (a_en_in && a_we_in) begin
            mem[a_addr_in] <= a_wdata_in;
        end
        if (b_en_in && b_we_in && !b_blocked) begin
            mem[b_addr_in] <= b_wdata_in;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (a_en_in) begin
            a_rdata_out <= mem[a_addr_in];
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (b_en_in) begin
            b_rdata_out <= mem[b_addr_in];
        end
    end

endmodule : dsda_dpram

//--- hw/dsda_core.sv
// Notes on behaviour
// - x and y are separate for dual-operand ops, one linear range otherwise.
// - two address units on separate paths fetch two words in one operation.
// - x space serves all modes; its read bus is apart from its write bus.
// - x read bus carries unified reads and the x operand prefetch.
// - y unit runs beside x for dual-operand ops, two reads together.
// - both units support modulo wrap for post- and pre-modified updates.
// - bit-reversed update only for x-space writes.
// - every write is addressed in the unified x plus y range.
// - x/y boundary is a fixed constant, not software writable.
// - effective addresses are 16-bit byte addresses, 64 kbyte range.
// - 1 kbyte dual-ported dma ram sits at the top of y space.
// - cpu and dma reach dma ram in the same cycle, no stolen cycles.
// - cpu write wins a same-location collision; cpu never stalls.
// - file direct mode uses the instruction address as operand location.
// - register indirect uses the base pointer contents as address.
// - post-modified uses the pointer, then adds the constant to it.
// - pre-modified adds the signed constant first, then uses the result.
// - indexed mode adds base and offset pointers.
// - literal-offset mode adds the instruction literal to the base pointer.
// - transfer ops use indexed mode plus 8-bit and 16-bit literals.
// - source and destination modes differ, sharing one 4-bit offset field.
// - prefetch pointers 8,9 feed the x unit; 10,11 feed the y unit.
module dsda_core
    import dsda_pkg::*;
(
    // clock and reset
    input  wire logic                 ref_clk_in,
    input  wire logic                 reset_n_in,
    // operation from the pipeline
    input  wire logic                 dual_op_in,
    input  wire dsda_req_s            src_req_in,
    input  wire dsda_req_s            dst_req_in,
    input  wire logic [WSEL_W-1:0]    offset_sel_in,
    input  wire logic                 lit8_in,
    input  wire logic [WSEL_W-1:0]    y_base_sel_in,
    input  wire dsda_mode_e           y_mode_in,
    input  wire logic [LIT_W-1:0]     y_step_in,
    input  wire logic [DATA_W-1:0]    wdata_in,
    input  wire dsda_modulo_s         x_mod_in,
    input  wire dsda_modulo_s         y_mod_in,
    input  wire logic [EA_W-1:0]      bitrev_mod_in,
    // working register file load port
    input  wire logic                 wreg_we_in,
    input  wire logic [WSEL_W-1:0]    wreg_sel_in,
    input  wire logic [DATA_W-1:0]    wreg_data_in,
    // dma controller port
    input  wire logic                 dma_en_in,
    input  wire logic                 dma_we_in,
    input  wire logic [DMA_IDX_W-1:0] dma_addr_in,
    input  wire logic [DATA_W-1:0]    dma_wdata_in,
    output logic      [DATA_W-1:0]    dma_rdata_out,
    // x read / x write / y read buses
    output logic                      x_rd_out,
    output logic      [EA_W-1:0]      x_rd_addr_out,
    output logic                      x_wr_out,
    output logic      [EA_W-1:0]      x_wr_addr_out,
    output logic      [DATA_W-1:0]    x_wr_data_out,
    output logic                      y_rd_out,
    output logic      [EA_W-1:0]      y_rd_addr_out,
    output logic      [DATA_W-1:0]    dma_cpu_rdata_out,
    output logic                      fault_out,
    output logic      [EA_W-1:0]      wreg_view_out [WREG_N]
);

    logic [DATA_W-1:0] wreg [WREG_N];
    logic [EA_W-1:0]   next_src_ea;
    logic [EA_W-1:0]   next_dst_ea;
    logic [EA_W-1:0]   next_y_ea;
    logic [EA_W-1:0]   next_src_base;
    logic [EA_W-1:0]   next_dst_base;
    logic [EA_W-1:0]   next_y_base;
    logic              src_upd;
    logic              dst_upd;
    logic              y_upd;
    logic [EA_W-1:0]   offset_val;
    logic [LIT_W-1:0]  src_lit;
    logic              bad_route;
    logic              cpu_dma_hit;
    logic              cpu_dma_we;
    logic [DMA_IDX_W-1:0] cpu_dma_idx;
    logic [EA_W-1:0]   y_sum;

    function automatic logic [EA_W-1:0] wrap_mod(input logic [EA_W-1:0] val,
                                                 input dsda_modulo_s m);
        logic [EA_W-1:0] r;
        r = val;
        if (m.en) begin
            if (val > m.stop) begin
                r = EA_W'(m.start + (val - m.stop) - MOD_STEP_LIM);
            end else if (val < m.start) begin
                r = EA_W'(m.stop - (m.start - val) + MOD_STEP_LIM);
            end
        end
        return r;
    endfunction : wrap_mod

    function automatic logic [EA_W-1:0] bit_rev_add(input logic [EA_W-1:0] ptr,
                                                    input logic [EA_W-1:0] span);
        logic [EA_W-1:0] pr;
        logic [EA_W-1:0] sr;
        logic [EA_W-1:0] sum;
        pr = '0;
        sr = '0;
        for (int i = 0; i < EA_W; i++) begin
            pr[i] = ptr[EA_W-1-i];
            sr[i] = span[EA_W-1-i];
        end
        sum = EA_W'(pr + sr);
        for (int i = 0; i < EA_W; i++) begin
            pr[i] = sum[EA_W-1-i];
        end
        return pr;
    endfunction : bit_rev_add

    // one generic address unit: effective address and pointer update
    task automatic form_ea(input  dsda_mode_e      mode,
                           input  logic [EA_W-1:0] base,
                           input  logic [LIT_W-1:0] lit,
                           input  logic [EA_W-1:0] ofs,
                           input  dsda_modulo_s    m,
                           output logic [EA_W-1:0] ea,
                           output logic [EA_W-1:0] nb,
                           output logic            upd);
        ea  = base;
        nb  = base;
        upd = 1'b0;
        unique case (mode)
            DSDA_FILE_DIRECT:  ea = lit;
            DSDA_REG_INDIRECT: ea = base;
            DSDA_POST_MOD: begin
                ea  = base;
                nb  = wrap_mod(EA_W'(base + lit), m);
                upd = 1'b1;
            end
            DSDA_PRE_MOD: begin
                nb  = wrap_mod(EA_W'(base + lit), m);
                ea  = nb;
                upd = 1'b1;
            end
            DSDA_REG_INDEXED:  ea = EA_W'(base + ofs);
            DSDA_LIT_OFFSET:   ea = EA_W'(base + lit);
        endcase
    endtask : form_ea

    // one offset field shared by source and destination
    assign offset_val = wreg[offset_sel_in];
    // short literals are sign extended from 8 bits
    assign src_lit = lit8_in ? {{8{src_req_in.literal[7]}}, src_req_in.literal[7:0]}
                             : src_req_in.literal;

    always_comb begin
        form_ea(src_req_in.mode, wreg[src_req_in.base_sel], src_lit, offset_val,
                x_mod_in, next_src_ea, next_src_base, src_upd);
        form_ea(dst_req_in.mode, wreg[dst_req_in.base_sel], dst_req_in.literal,
                offset_val, x_mod_in, next_dst_ea, next_dst_base, dst_upd);
        form_ea(y_mode_in, wreg[y_base_sel_in], y_step_in, offset_val,
                y_mod_in, next_y_ea, next_y_base, y_upd);
        // bit-reversed stepping only on an x-space destination write
        if (dst_req_in.write && dst_req_in.bitrev && dst_req_in.mode == DSDA_POST_MOD
            && next_dst_ea < XY_BOUNDARY) begin
            next_dst_base = bit_rev_add(wreg[dst_req_in.base_sel], bitrev_mod_in);
        end
    end

    assign y_sum = next_y_ea;

    // dual-operand pointers must sit in their fixed unit
    always_comb begin
        bad_route = 1'b0;
        if (dual_op_in && src_req_in.valid) begin
            bad_route = !(src_req_in.base_sel == PF_X_LO || src_req_in.base_sel == PF_X_HI)
                     || !(y_base_sel_in == PF_Y_LO || y_base_sel_in == PF_Y_HI)
                     || next_src_ea >= XY_BOUNDARY || y_sum < XY_BOUNDARY;
        end
    end

    // cpu side of the dma ram: writes use the unified range
    assign cpu_dma_we  = dst_req_in.valid && dst_req_in.write && next_dst_ea >= DMA_BASE;
    assign cpu_dma_hit = cpu_dma_we || (src_req_in.valid && !dual_op_in
                                        && next_src_ea >= DMA_BASE);
    assign cpu_dma_idx = cpu_dma_we ? next_dst_ea[DMA_IDX_W:1] : next_src_ea[DMA_IDX_W:1];

    dsda_dpram dsda_dpram_inst (
        .ref_clk_in  (ref_clk_in),
        .a_en_in     (cpu_dma_hit),
        .a_we_in     (cpu_dma_we),
        .a_addr_in   (cpu_dma_idx),
        .a_wdata_in  (wdata_in),
        .a_rdata_out (dma_cpu_rdata_out),
        .b_en_in     (dma_en_in),
        .b_we_in     (dma_we_in),
        .b_addr_in   (dma_addr_in),
        .b_wdata_in  (dma_wdata_in),
        .b_rdata_out (dma_rdata_out)
    );

    // pointer file: external load wins, then y, then destination, then source
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            for (int i = 0; i < WREG_N; i++) begin
                wreg[i] <= '0;
            end
        end else begin
            if (src_req_in.valid && src_upd && !bad_route) begin
                wreg[src_req_in.base_sel] <= next_src_base;
            end
            if (dst_req_in.valid && dst_upd) begin
                wreg[dst_req_in.base_sel] <= next_dst_base;
            end
            if (dual_op_in && y_upd && !bad_route) begin
                wreg[y_base_sel_in] <= next_y_base;
            end
            if (wreg_we_in) begin
                wreg[wreg_sel_in] <= wreg_data_in;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < WREG_N; g++) begin : g_view
            assign wreg_view_out[g] = wreg[g];
        end
    endgenerate

    // x read bus: unified reads and x prefetch; bus outputs are registered
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            x_rd_out      <= 1'b0;
            x_rd_addr_out <= '0;
        end else begin
            x_rd_out      <= src_req_in.valid && !src_req_in.write && !bad_route;
            x_rd_addr_out <= next_src_ea;
        end
    end

    // y read bus only runs for dual-operand operations
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            y_rd_out      <= 1'b0;
            y_rd_addr_out <= '0;
        end else begin
            y_rd_out      <= dual_op_in && !bad_route;
            y_rd_addr_out <= y_sum;
        end
    end

    // single write bus on the unified range; boundary is a package constant
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            x_wr_out      <= 1'b0;
            x_wr_addr_out <= '0;
            x_wr_data_out <= '0;
        end else begin
            x_wr_out      <= dst_req_in.valid && dst_req_in.write;
            x_wr_addr_out <= next_dst_ea;
            x_wr_data_out <= wdata_in;
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            fault_out <= 1'b0;
        end else begin
            fault_out <= bad_route;
        end
    end

    // the 16-bit ea width gives the 64 kbyte byte range
    a_post_mod_ptr: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        src_req_in.valid && src_req_in.mode == DSDA_POST_MOD && !x_mod_in.en && !bad_route
        && !wreg_we_in && !dst_req_in.valid && !dual_op_in
        |=> wreg[$past(src_req_in.base_sel)] == $past(EA_W'(wreg[src_req_in.base_sel] + src_lit))
            && x_rd_addr_out == $past(wreg[src_req_in.base_sel]))
        else $error("post-modify pointer or address wrong");
    a_pre_mod_ea: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        src_req_in.valid && src_req_in.mode == DSDA_PRE_MOD && !x_mod_in.en
        |=> x_rd_addr_out == $past(EA_W'(wreg[src_req_in.base_sel] + src_lit)))
        else $error("pre-modify address wrong");
    a_indexed_ea: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        src_req_in.valid && src_req_in.mode == DSDA_REG_INDEXED
        |=> x_rd_addr_out == $past(EA_W'(wreg[src_req_in.base_sel] + offset_val)))
        else $error("indexed address wrong");
    a_direct_ea: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        src_req_in.valid && src_req_in.mode == DSDA_FILE_DIRECT |=> x_rd_addr_out == $past(src_lit))
        else $error("file direct address wrong");
    a_indirect_ea: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        src_req_in.valid && src_req_in.mode == DSDA_REG_INDIRECT
        |=> x_rd_addr_out == $past(wreg[src_req_in.base_sel]))
        else $error("indirect address wrong");
    a_lit_ofs_ea: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        dst_req_in.valid && dst_req_in.write && dst_req_in.mode == DSDA_LIT_OFFSET
        |=> x_wr_out && x_wr_addr_out == $past(EA_W'(wreg[dst_req_in.base_sel]
                                                   + dst_req_in.literal)))
        else $error("literal offset write address wrong");
    a_dual_read: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        dual_op_in && src_req_in.valid && !src_req_in.write && !bad_route
        |=> x_rd_out && y_rd_out)
        else $error("dual read paths not concurrent");
    a_route_fault: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        dual_op_in && src_req_in.valid && src_req_in.base_sel == PF_Y_LO
        |=> fault_out && !y_rd_out)
        else $error("y pointer accepted on x unit");
    a_write_nostall: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        dst_req_in.valid && dst_req_in.write |=> x_wr_out && x_wr_data_out == $past(wdata_in))
        else $error("cpu write stalled");

    c_dual: cover property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        x_rd_out && y_rd_out);
    c_dma_clash: cover property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        cpu_dma_we && dma_en_in && dma_we_in && cpu_dma_idx == dma_addr_in);
    c_mod_wrap: cover property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        src_req_in.valid && src_upd && x_mod_in.en && next_src_base == x_mod_in.start);

endmodule : dsda_core

//--- dv/dsda_dma_model.sv
module dsda_dma_model
    import dsda_pkg::*;
(
    // clock
    input  wire logic                 ref_clk_in,
    // dma port of the core
    output logic                      en_out,
    output logic                      we_out,
    output logic      [DMA_IDX_W-1:0] addr_out,
    output logic      [DATA_W-1:0]    wdata_out,
    input  wire logic [DATA_W-1:0]    rdata_in
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        en_out = 1'b0;
        we_out = 1'b0;
        addr_out = '0;
        wdata_out = '0;
    end

    // one access per call, never waits on the cpu side
    task automatic access(input logic we, input logic [DMA_IDX_W-1:0] idx,
                          input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
        @(posedge ref_clk_in);
        en_out <= 1'b1;
        we_out <= we;
        addr_out <= idx;
        wdata_out <= d;
        @(posedge ref_clk_in);
        en_out <= 1'b0;
        we_out <= 1'b0;
        // released lines must not keep the last value
        addr_out <= ~idx;
        wdata_out <= ~d;
        #1;
        q = rdata_in;
    endtask : access
endmodule : dsda_dma_model

//--- dv/dual_space_data_addressing_tb.sv
module dual_space_data_addressing_tb
    import dsda_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk, rst_n, dual, lit8, wwe, den, dwe, xrd, xwr, yrd, flt;
    logic n_dual, n_l8, e_xrd, e_xwr, e_yrd, e_flt;
    dsda_req_s src, dst, ns, nd;
    dsda_mode_e ymode, n_ym;
    dsda_modulo_s xm, ym;
    logic [3:0] ofs, ysel, wsel, n_ofs, n_ysel, b, db;
    logic [15:0] ystep, wd, brm, wdat, ddat, drd, xra, xwa, xwd, yra, crd;
    logic [15:0] n_ys, n_wd, e_xra, e_xwa, e_yra, lit, el, q, v;
    logic [DMA_IDX_W-1:0] dadr;
    logic [15:0] wv [WREG_N];
    logic [15:0] w [WREG_N];
    logic [15:0] xv [4] = '{16'h07fe, 16'h0800, 16'h0200, 16'h0100};
    logic [15:0] yv [4] = '{16'h0800, 16'h0900, 16'h07fe, 16'h0900};
    int fails = 0;
    int n_checks = 0;
    int cyc = 0;

    dsda_core dsda_core_inst (.ref_clk_in(clk), .reset_n_in(rst_n), .dual_op_in(dual),
        .src_req_in(src), .dst_req_in(dst), .offset_sel_in(ofs), .lit8_in(lit8),
        .y_base_sel_in(ysel), .y_mode_in(ymode), .y_step_in(ystep), .wdata_in(wd),
        .x_mod_in(xm), .y_mod_in(ym), .bitrev_mod_in(brm), .wreg_we_in(wwe),
        .wreg_sel_in(wsel), .wreg_data_in(wdat), .dma_en_in(den), .dma_we_in(dwe),
        .dma_addr_in(dadr), .dma_wdata_in(ddat), .dma_rdata_out(drd), .x_rd_out(xrd),
        .x_rd_addr_out(xra), .x_wr_out(xwr), .x_wr_addr_out(xwa), .x_wr_data_out(xwd),
        .y_rd_out(yrd), .y_rd_addr_out(yra), .dma_cpu_rdata_out(crd), .fault_out(flt),
        .wreg_view_out(wv));

    dsda_dma_model dsda_dma_model_inst (.ref_clk_in(clk), .en_out(den), .we_out(dwe),
        .addr_out(dadr), .wdata_out(ddat), .rdata_in(drd));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic conclude();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : conclude

    // a hang ends the run as a failure
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            fails++;
            conclude();
        end
    end

    task automatic chk_word(input string what, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask : chk_word

    task automatic chk_bit(input string what, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %b seen %b", what, e, g);
        end
    endtask : chk_bit

    function automatic dsda_req_s mk(logic vl, logic wr, dsda_mode_e m, logic [3:0] bs,
                                     logic [15:0] l);
        return '{valid: vl, write: wr, mode: m, base_sel: bs, literal: l, bitrev: 1'b0};
    endfunction : mk

    // reference address former, pointer updates land in w at once
    task automatic calc(input dsda_mode_e m, input logic [3:0] bs, input logic [15:0] l,
                        output logic [15:0] ea);
        case (m)
            DSDA_FILE_DIRECT: ea = l;
            DSDA_POST_MOD: begin
                ea = w[bs];
                w[bs] = w[bs] + l;
            end
            DSDA_PRE_MOD: begin
                w[bs] = w[bs] + l;
                ea = w[bs];
            end
            DSDA_REG_INDEXED: ea = w[bs] + w[n_ofs];
            DSDA_LIT_OFFSET: ea = w[bs] + l;
            default: ea = w[bs];
        endcase
    endtask : calc

    task automatic load(input logic [3:0] i, input logic [15:0] val);
        @(posedge clk);
        wwe <= 1'b1;
        wsel <= i;
        wdat <= val;
        @(posedge clk);
        wwe <= 1'b0;
        w[i] = val;
        #1;
        chk_word("pointer load", val, wv[i]);
    endtask : load

    // one request cycle, then every result compared with the model
    task automatic issue();
        @(posedge clk);
        src <= ns;
        dst <= nd;
        dual <= n_dual;
        lit8 <= n_l8;
        ofs <= n_ofs;
        ysel <= n_ysel;
        ymode <= n_ym;
        ystep <= n_ys;
        wd <= n_wd;
        @(posedge clk);
        src <= '0;
        dst <= '0;
        dual <= 1'b0;
        #1;
        chk_bit("x read", e_xrd, xrd);
        if (e_xrd) chk_word("x read addr", e_xra, xra);
        chk_bit("x write", e_xwr, xwr);
        if (e_xwr) chk_word("x write addr", e_xwa, xwa);
        if (e_xwr) chk_word("x write data", n_wd, xwd);
        chk_bit("y read", e_yrd, yrd);
        if (e_yrd) chk_word("y read addr", e_yra, yra);
        chk_bit("fault", e_flt, flt);
        for (int i = 0; i < WREG_N; i++) chk_word("pointer", w[i], wv[i]);
    endtask : issue

    initial begin
        {rst_n, dual, lit8, wwe, n_dual, n_l8} = '0;
        {src, dst, ns, nd, xm, ym} = '0;
        {ofs, ysel, wsel, n_ofs, n_ysel, ystep, wd, brm, wdat, n_ys, n_wd} = '0;
        ymode = DSDA_REG_INDIRECT;
        n_ym = DSDA_REG_INDIRECT;
        void'($urandom(20730));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        for (int i = 0; i < WREG_N; i++) w[i] = 16'h0000;
        for (int i = 0; i < WREG_N; i++) chk_word("pointer reset", w[i], wv[i]);
        for (int i = 0; i < WREG_N; i++) load(4'(i), 16'($urandom));
        {e_yrd, e_flt} = '0;
        e_xrd = 1'b1;
        for (int k = 0; k < 6; k++) begin
            for (int r = 0; r < 2; r++) begin
                b = 4'($urandom_range(0, 7));
                db = b + 4'h8;
                n_ofs = 4'($urandom);
                lit = 16'($urandom);
                if (k == 2 || k == 3) lit = {{12{lit[3]}}, lit[3:1], 1'b0};
                n_l8 = (k == 5 && r == 1);
                el = n_l8 ? {{8{lit[7]}}, lit[7:0]} : lit;
                n_wd = 16'($urandom);
                ns = mk(1'b1, 1'b0, dsda_mode_e'(k), b, lit);
                nd = mk(r == 1, 1'b1, (k % 2) ? DSDA_LIT_OFFSET : DSDA_REG_INDEXED, db, ~lit);
                e_xwr = (r == 1);
                e_xwa = (k % 2) ? w[db] + ~lit : w[db] + w[n_ofs];
                calc(dsda_mode_e'(k), b, el, e_xra);
                issue();
            end
        end
        n_l8 = 1'b0;
        load(4'h8, 16'h0100);
        load(4'ha, 16'h0900);
        n_dual = 1'b1;
        n_ysel = 4'ha;
        n_ym = DSDA_POST_MOD;
        n_ys = 16'h0004;
        ns = mk(1'b1, 1'b0, DSDA_POST_MOD, 4'h8, 16'h0002);
        nd = '0;
        e_xwr = 1'b0;
        calc(DSDA_POST_MOD, 4'h8, 16'h0002, e_xra);
        calc(DSDA_POST_MOD, 4'ha, 16'h0004, e_yra);
        // both units step past the buffer end and wrap back to its start
        xm = '{1'b1, 16'h00fc, 16'h0100};
        ym = '{1'b1, 16'h0900, 16'h0902};
        w[8] = 16'h00fc;
        w[10] = 16'h0900;
        e_yrd = 1'b1;
        issue();
        {xm, ym} = '0;
        // boundary accepted, then three refusals
        for (int c = 0; c < 4; c++) begin
            b = (c == 3) ? 4'ha : 4'h9;
            load(4'h9, xv[c]);
            load(4'hb, yv[c]);
            ns = mk(1'b1, 1'b0, DSDA_REG_INDIRECT, b, 16'h0000);
            n_ysel = 4'hb;
            n_ym = DSDA_REG_INDIRECT;
            e_flt = (c != 0);
            e_xrd = !e_flt;
            e_yrd = !e_flt;
            e_xra = w[b];
            e_yra = w[11];
            issue();
        end
        {n_dual, e_xrd, e_yrd, e_flt} = '0;
        // reversed carry only for an x-space write; y-space steps plainly
        brm = 16'h0008;
        load(4'h5, 16'h0008);
        ns = '0;
        nd = mk(1'b1, 1'b1, DSDA_POST_MOD, 4'h5, 16'h0002);
        nd.bitrev = 1'b1;
        e_xwr = 1'b1;
        e_xwa = 16'h0008;
        w[5] = 16'h0004;
        issue();
        load(4'h6, 16'h0900);
        nd.base_sel = 4'h6;
        e_xwa = 16'h0900;
        w[6] = 16'h0902;
        issue();
        load(4'h1, DMA_BASE + 16'h000a);
        load(4'h2, DMA_BASE + 16'h000e);
        ns = '0;
        nd = mk(1'b1, 1'b1, DSDA_REG_INDIRECT, 4'h1, 16'h0000);
        n_wd = 16'($urandom);
        e_xwr = 1'b1;
        e_xwa = w[1];
        fork
            issue();
            dsda_dma_model_inst.access(1'b1, 9'h005, ~n_wd, q);
        join
        dsda_dma_model_inst.access(1'b0, 9'h005, 16'h0000, q);
        chk_word("ram after clash", n_wd, q);
        v = 16'($urandom);
        dsda_dma_model_inst.access(1'b1, 9'h007, v, q);
        ns = mk(1'b1, 1'b0, DSDA_REG_INDIRECT, 4'h2, 16'h0000);
        nd = '0;
        e_xrd = 1'b1;
        e_xra = w[2];
        e_xwr = 1'b0;
        fork
            issue();
            dsda_dma_model_inst.access(1'b0, 9'h007, 16'h0000, q);
        join
        chk_word("dma port read", v, q);
        chk_word("cpu side ram read", v, crd);
        conclude();
    end
endmodule : dual_space_data_addressing_tb
